// >>> include/dapr_pkg.sv
// Package with register map, field positions and reset values for the DAC power/readback block
package dapr_pkg;
  localparam logic [7:0] ADDR_POWER = 8'h00;
  localparam logic [7:0] ADDR_MODE = 8'h01;
  localparam logic [7:0] ADDR_CABLE = 8'h10;
  localparam logic [7:0] ADDR_RB0 = 8'h12;
  localparam logic [7:0] ADDR_RB1 = 8'h13;
  localparam logic [7:0] ADDR_RB2 = 8'h14;
  localparam logic [7:0] ADDR_RB3 = 8'h15;
  localparam logic [7:0] ADDR_RB4 = 8'h16;
  localparam logic [7:0] ADDR_RESET = 8'h17;
  localparam int BIT_SENSE1 = 0;
  localparam int BIT_SENSE2 = 1;
  localparam int BIT_SENSE_EN = 2;
  localparam int BIT_AUTO_PD = 4;
  localparam int BIT_SOFT_RST = 1;
  localparam int BIT_PORT_SPI = 0;
  localparam int BIT_COMPONENT = 0;
  localparam logic [2:0] POWER_RESET = 3'h0;
  localparam logic [2:0] CABLE_CTRL_RESET = 3'h0;
  localparam logic [1:0] SENSE_RESET = 2'h3;
  localparam logic MODE_RESET = 1'b0;
  localparam int POR_CYCLES = 16;
  localparam logic [4:0] POR_LAST = 5'(POR_CYCLES - 1);
endpackage

// >>> hw/dapr_top.sv
// DAC auto power-down, input readback and reset control
//
// The register addresses and register access over Avalon-MM were left to the implementer.
`timescale 1ns/10ps
// Operation
// - Auto power-down enable at 0x10 bit 4
// - Auto power-down needs cable sensing enabled
// - Sample DAC connection once per frame
// - Composite: DAC1 open powers DAC1 only
// - Composite: DAC2 open powers DAC2 and DAC3
// - Component: DAC1 open powers all three
// - Sensed state holds for whole frame
// - Pin levels readable at 0x12 to 0x16
// - Write 1 to 0x17 bit 1 resets registers
// - Software reset bit clears itself
// - Software reset keeps SPI port mode
// - Power-on reset initialises registers, DAC power and port mode
// - Sense results to 0x10 bits 0, 1
// - Only powered DACs are monitored
module dapr_top (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic frame_start,
  input wire logic [1:0] cable_absent,
  input wire logic spi_select,
  input wire logic [9:0] pix_s,
  input wire logic [9:0] pix_y,
  input wire logic [9:0] pix_c,
  input wire logic [4:0] sync_blank_n,
  input wire logic subcarrier_lock_serial_out_pin,
  output logic [2:0] dac_power_on,
  output logic port_spi_mode
);

  // Power-on reset: counter starts at zero from the flop init value
  logic [4:0] por_cnt_reg = 5'h00;
  logic por_done_reg = 1'b0;
  logic soft_rst_reg;
  logic regs_rst;

  always_ff @(posedge ref_clk)
  begin
    if (!por_done_reg)
    begin
      por_cnt_reg <= por_cnt_reg + 5'h01;
      if (por_cnt_reg == dapr_pkg::POR_LAST)
        por_done_reg <= 1'b1;
    end
  end

  assign regs_rst = rst || !por_done_reg || soft_rst_reg;

  // Two-stage synchronisers for pins
  logic [35:0] pin_meta_reg;
  logic [35:0] pin_sync_reg;
  logic [1:0] sense_meta_reg;
  logic [1:0] sense_sync_reg;
  logic [1:0] frame_meta_reg;
  logic frame_sync_reg;
  logic frame_prev_reg;
  logic spi_meta_reg;
  logic spi_sync_reg;
  logic frame_pulse;

  always_ff @(posedge ref_clk)
  begin
    pin_meta_reg <= {subcarrier_lock_serial_out_pin, sync_blank_n, pix_c, pix_y, pix_s};
    pin_sync_reg <= pin_meta_reg;
    sense_meta_reg <= cable_absent;
    sense_sync_reg <= sense_meta_reg;
    frame_meta_reg <= {frame_meta_reg[0], frame_start};
    frame_sync_reg <= frame_meta_reg[0];
    frame_prev_reg <= frame_sync_reg;
    spi_meta_reg <= spi_select;
    spi_sync_reg <= spi_meta_reg;
  end

  assign frame_pulse = frame_sync_reg && !frame_prev_reg;

  // Registers
  logic [2:0] power_ctrl_reg;
  logic component_mode_reg;
  logic auto_pd_reg;
  logic sense_en_reg;
  logic [1:0] sense_reg;
  logic wr_acc;
  logic rd_acc;

  // A write lands at the edge where the master samples waitrequest low
  assign wr_acc = avs_write && !avs_waitrequest;
  assign rd_acc = avs_read && avs_waitrequest;

  always_ff @(posedge ref_clk)
  begin
    if (regs_rst)
    begin
      power_ctrl_reg <= dapr_pkg::POWER_RESET;
      component_mode_reg <= dapr_pkg::MODE_RESET;
      auto_pd_reg <= 1'b0;
      sense_en_reg <= 1'b0;
    end
    else if (wr_acc)
    begin
      if (avs_address == dapr_pkg::ADDR_POWER)
        power_ctrl_reg <= avs_writedata[2:0];
      if (avs_address == dapr_pkg::ADDR_MODE)
        component_mode_reg <= avs_writedata[dapr_pkg::BIT_COMPONENT];
      if (avs_address == dapr_pkg::ADDR_CABLE)
      begin
        auto_pd_reg <= avs_writedata[dapr_pkg::BIT_AUTO_PD];
        sense_en_reg <= avs_writedata[dapr_pkg::BIT_SENSE_EN];
      end
    end
  end

  // Self-clearing software reset pulse
  always_ff @(posedge ref_clk)
  begin
    if (rst || !por_done_reg)
      soft_rst_reg <= 1'b0;
    else
      soft_rst_reg <= wr_acc && (avs_address == dapr_pkg::ADDR_RESET)
                      && avs_writedata[dapr_pkg::BIT_SOFT_RST];
  end

  // Port mode survives software reset; only power-on or hard reset returns to I2C
  always_ff @(posedge ref_clk)
  begin
    if (rst || !por_done_reg)
      port_spi_mode <= 1'b0;
    else if (spi_sync_reg)
      port_spi_mode <= 1'b1;
  end

  // Frame sampling of cable sense
  logic mon1;
  logic mon2;
  assign mon1 = sense_en_reg && power_ctrl_reg[0];
  assign mon2 = sense_en_reg && power_ctrl_reg[1] && !component_mode_reg;

  always_ff @(posedge ref_clk)
  begin
    if (regs_rst)
      sense_reg <= dapr_pkg::SENSE_RESET;
    else if (frame_pulse)
    begin
      if (mon1)
        sense_reg[0] <= sense_sync_reg[0];
      if (mon2)
        sense_reg[1] <= sense_sync_reg[1];
    end
  end

  // DAC power decision
  logic auto_active;
  logic [2:0] auto_mask;
  logic [1:0] open_now;
  assign auto_active = auto_pd_reg && sense_en_reg;
  assign open_now = {mon2 && sense_sync_reg[1], mon1 && sense_sync_reg[0]};

  always_comb
  begin
    auto_mask = 3'h7;
    if (component_mode_reg)
    begin
      if (open_now[0])
        auto_mask = 3'h0;
    end
    else
    begin
      if (open_now[0])
        auto_mask[0] = 1'b0;
      if (open_now[1])
        auto_mask[2:1] = 2'h0;
    end
  end

  logic [2:0] auto_mask_reg;
  always_ff @(posedge ref_clk)
  begin
    if (regs_rst)
      auto_mask_reg <= 3'h7;
    else if (frame_pulse)
      auto_mask_reg <= auto_mask;
  end

  always_ff @(posedge ref_clk)
  begin
    if (regs_rst)
      dac_power_on <= 3'h0;
    else if (!auto_active)
      dac_power_on <= power_ctrl_reg;
    else
      dac_power_on <= power_ctrl_reg & auto_mask_reg;
  end

  // Avalon slave: one wait cycle, answer on the second
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      avs_waitrequest <= 1'b1;
    else if (!avs_waitrequest)
      avs_waitrequest <= 1'b1;
    else
      avs_waitrequest <= !((avs_read || avs_write) && !regs_rst);
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      avs_readdata <= 32'h0000_0000;
    else if (rd_acc)
    begin
      unique case (avs_address)
        dapr_pkg::ADDR_POWER: avs_readdata <= {29'h0, power_ctrl_reg};
        dapr_pkg::ADDR_MODE: avs_readdata <= {31'h0, component_mode_reg};
        dapr_pkg::ADDR_CABLE: avs_readdata <= {27'h0, auto_pd_reg, 1'b0, sense_en_reg,
                                               sense_reg};
        dapr_pkg::ADDR_RB0: avs_readdata <= {24'h0, pin_sync_reg[7:0]};
        dapr_pkg::ADDR_RB1: avs_readdata <= {24'h0, pin_sync_reg[15:8]};
        dapr_pkg::ADDR_RB2: avs_readdata <= {24'h0, pin_sync_reg[23:16]};
        dapr_pkg::ADDR_RB3: avs_readdata <= {24'h0, pin_sync_reg[31:24]};
        dapr_pkg::ADDR_RB4: avs_readdata <= {28'h0, pin_sync_reg[35:32]};
        dapr_pkg::ADDR_RESET: avs_readdata <= {30'h0, 1'b0, port_spi_mode};
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // Assertions
  a_soft_rst_clear: assert property (@(posedge ref_clk) disable iff (rst)
    soft_rst_reg |=> !soft_rst_reg) else $error("soft reset not self clearing");
  a_soft_rst_regs: assert property (@(posedge ref_clk) disable iff (rst)
    soft_rst_reg |=> power_ctrl_reg == 3'h0 && !auto_pd_reg)
    else $error("soft reset left registers");
  a_spi_kept: assert property (@(posedge ref_clk) disable iff (rst)
    port_spi_mode && por_done_reg |=> port_spi_mode) else $error("spi mode lost");
  a_mask_stable: assert property (@(posedge ref_clk) disable iff (rst || regs_rst)
    !frame_pulse |=> $stable(auto_mask_reg)) else $error("mask changed mid frame");
  a_manual_power: assert property (@(posedge ref_clk) disable iff (rst || regs_rst)
    !auto_active ##1 !auto_active && $stable(power_ctrl_reg) |-> dac_power_on == power_ctrl_reg)
    else $error("power not following register");
  a_no_sense_off: assert property (@(posedge ref_clk) disable iff (rst)
    !sense_en_reg && !regs_rst |=> dac_power_on == $past(power_ctrl_reg))
    else $error("power down without sensing");
  a_power_subset: assert property (@(posedge ref_clk) disable iff (rst)
    (dac_power_on & ~$past(power_ctrl_reg)) == 3'h0) else $error("dac on without bit");
  a_comp_all_off: assert property (@(posedge ref_clk) disable iff (rst || regs_rst)
    frame_pulse && component_mode_reg && open_now[0] |=> auto_mask_reg == 3'h0)
    else $error("component power down wrong");
  a_sense_update: assert property (@(posedge ref_clk) disable iff (rst || regs_rst)
    frame_pulse && mon1 |=> sense_reg[0] == $past(sense_sync_reg[0]))
    else $error("sense bit not updated");
  a_bus_answer: assert property (@(posedge ref_clk) disable iff (rst)
    (avs_read || avs_write) && avs_waitrequest && !regs_rst |=> !avs_waitrequest)
    else $error("no bus answer");

endmodule

// >>> verif/dapr_host.sv
// Host processor model driving the Avalon-MM register port
`timescale 1ns/10ps
module dapr_host (
  input wire logic ref_clk,
  output logic [7:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  initial
  begin
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
  end
  // Called just after a rising edge; the request stands until the answer edge
  task automatic xfer(input logic rd, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= rd;
    avs_write <= !rd;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge ref_clk);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // Idle edge keeps the two-cycle spacing between accesses
    @(posedge ref_clk);
  endtask
endmodule

// >>> verif/dapr_top_bench.sv
// Self-checking bench for DAC power-down, readback and reset control
`timescale 1ns/10ps
module dapr_top_bench;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic frame_start = 1'b0;
  logic [1:0] cable_absent = 2'h0;
  logic spi_select = 1'b0;
  logic [9:0] pix_s = 10'h2A5;
  logic [9:0] pix_y = 10'h1C3;
  logic [9:0] pix_c = 10'h35A;
  logic [4:0] sync_blank_n = 5'h15;
  logic sfl = 1'b1;
  logic [7:0] adr;
  logic rd_q, wr_q, wt;
  logic [31:0] wd, rdat, q;
  logic [2:0] dac_power_on;
  logic port_spi_mode;
  int fails = 0;
  int checks = 0;
  always #12.5 ref_clk = ~ref_clk;
  dapr_top DUT (.ref_clk(ref_clk), .rst(rst), .avs_address(adr), .avs_read(rd_q),
    .avs_write(wr_q), .avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wt),
    .frame_start(frame_start), .cable_absent(cable_absent), .spi_select(spi_select),
    .pix_s(pix_s), .pix_y(pix_y), .pix_c(pix_c), .sync_blank_n(sync_blank_n),
    .subcarrier_lock_serial_out_pin(sfl), .dac_power_on(dac_power_on),
    .port_spi_mode(port_spi_mode));
  dapr_host host (.ref_clk(ref_clk), .avs_address(adr), .avs_read(rd_q), .avs_write(wr_q),
    .avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wt));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b0, a, d, q);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    host.xfer(1'b1, a, 32'h0, q);
    chk(q, e);
  endtask
  // Two boundaries so sense capture and the power mask from the synchronised pins have both settled
  task automatic frames;
    repeat (2)
    begin
      frame_start <= 1'b1;
      repeat (3) @(posedge ref_clk);
      frame_start <= 1'b0;
      repeat (8) @(posedge ref_clk);
    end
  endtask
  task automatic t_por;
    chk({29'h0, dac_power_on}, 32'h0);
    rd_chk(dapr_pkg::ADDR_CABLE, 32'h3);
    $display("por test done");
  endtask
  task automatic t_auto;
    logic [7:0] ctl [6] = '{8'h14, 8'h14, 8'h14, 8'h14, 8'h10, 8'h04};
    logic [0:0] md [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
    logic [1:0] ab [6] = '{2'h1, 2'h2, 2'h1, 2'h2, 2'h3, 2'h3};
    logic [2:0] ex [6] = '{3'h6, 3'h1, 3'h0, 3'h7, 3'h7, 3'h7};
    wr(dapr_pkg::ADDR_POWER, 32'h7);
    for (int i = 0; i < 6; i++)
    begin
      wr(dapr_pkg::ADDR_MODE, {31'h0, md[i]});
      wr(dapr_pkg::ADDR_CABLE, {24'h0, ctl[i]});
      cable_absent <= ab[i];
      frames();
      chk({29'h0, dac_power_on}, {29'h0, ex[i]});
      if (i == 0)
        rd_chk(dapr_pkg::ADDR_CABLE, 32'h15);
    end
    $display("auto power-down test done");
  endtask
  task automatic t_readback;
    logic [35:0] cat;
    cat = {sfl, sync_blank_n, pix_c, pix_y, pix_s};
    for (int i = 0; i < 4; i++)
      rd_chk(dapr_pkg::ADDR_RB0 + 8'(i), {24'h0, cat[8*i+:8]});
    rd_chk(dapr_pkg::ADDR_RB4, {28'h0, cat[35:32]});
    $display("readback test done");
  endtask
  task automatic t_soft_reset;
    spi_select <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk({31'h0, port_spi_mode}, 32'h1);
    wr(dapr_pkg::ADDR_RESET, 32'h2);
    repeat (2) @(posedge ref_clk);
    rd_chk(dapr_pkg::ADDR_RESET, 32'h1);
    rd_chk(dapr_pkg::ADDR_POWER, 32'h0);
    rd_chk(dapr_pkg::ADDR_CABLE, 32'h3);
    $display("soft reset test done");
  endtask
  task automatic give_verdict;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    #(25 * 4000);
    fails++;
    give_verdict();
  end
  initial
  begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (20) @(posedge ref_clk);
    t_por();
    t_auto();
    t_readback();
    t_soft_reset();
    give_verdict();
  end
endmodule
